// >>> logic/sma_params.svh
`ifndef SMA_PARAMS_SVH
`define SMA_PARAMS_SVH

// Peripheral-bus addresses of the step-math registers.
`define SMA_ADDR_PSEUDO 5'h05
`define SMA_ADDR_DIVISOR 5'h06
`define SMA_ADDR_ROOT 5'h07

// Opcode field positions.
`define SMA_SIGN_BIT 0
`define SMA_SHIFT_LSB 1
`define SMA_IR3_BIT 3
`define SMA_COND_LSB 6
`define SMA_SEL_BIT 8
`define SMA_ALU_LSB 9

// A pseudo-register write multiplies by 256, a shift of this many bits.
`define SMA_PSEUDO_SHIFT 8

// Reset values.
`define SMA_RST_WORD 16'h0000
`define SMA_RST_BIT 1'b0

`endif

// >>> logic/sma_pkg.sv
`default_nettype none

package sma_pkg;

    // Conditional ALU operation selected by the three-bit ALU field.
    typedef enum logic [2:0] {
        SMA_ALU_NOP = 3'b000,
        SMA_ALU_AND = 3'b001,
        SMA_ALU_TSUB = 3'b010,
        SMA_ALU_OR = 3'b011,
        SMA_ALU_ADD = 3'b100,
        SMA_ALU_XOR = 3'b101,
        SMA_ALU_RSUB = 3'b110,
        SMA_ALU_LOAD = 3'b111
    } sma_alu_e;

    // Unconditional shift applied after the ALU.
    typedef enum logic [2:0] {
        SMA_SH_NONE = 3'b000,
        SMA_SH_LEFT = 3'b001,
        SMA_SH_CRIGHT = 3'b010,
        SMA_SH_RIGHT = 3'b011,
        SMA_SH_NRIGHT = 3'b100,
        SMA_SH_DLEFT = 3'b101,
        SMA_SH_CDRIGHT = 3'b110,
        SMA_SH_DRIGHT = 3'b111
    } sma_shift_e;

    // Every stored bit of the datapath.
    typedef struct packed {
        logic [15:0] top;
        logic [15:0] next;
        logic [15:0] divisor;
        logic [15:0] root;
        logic ext_low;
        logic ext_high;
        logic [15:0] rd_data;
        logic rd_valid;
    } sma_state_s;

endpackage : sma_pkg

`default_nettype wire

// >>> logic/sma_shifter.sv
`default_nettype none

// Post-ALU shifter: turns the 18-bit intermediate result into new extension bits,
// top and next in the same cycle as the ALU, so data never passes the ALU twice.
module sma_shifter (
    input wire logic [17:0] i_w,
    input wire logic [15:0] i_next,
    input wire logic i_yes,
    input wire logic [2:0] i_shift,
    output logic o_ext_high,
    output logic o_ext_low,
    output logic [15:0] o_top,
    output logic [15:0] o_next
);

    // One case selects every output bit for each shift code.
    always_comb begin
        o_ext_high = i_w[17];
        o_ext_low = i_w[16];
        o_top = i_w[15:0];
        o_next = i_next;
        case (sma_pkg::sma_shift_e'(i_shift))
            sma_pkg::SMA_SH_NONE: begin
                o_top = i_w[15:0];
            end
            sma_pkg::SMA_SH_LEFT: begin
                o_ext_high = i_w[16];
                o_ext_low = i_w[15];
                o_top = {i_w[14:0], i_yes};
            end
            sma_pkg::SMA_SH_CRIGHT: begin
                o_ext_low = i_w[17];
                o_top = i_w[16:1];
            end
            sma_pkg::SMA_SH_RIGHT: begin
                o_ext_low = i_w[17];
                o_top = {i_yes, i_w[15:1]};
            end
            sma_pkg::SMA_SH_NRIGHT: begin
                // Only next moves; its sign is kept.
                o_next = {i_next[15], i_next[15:1]};
            end
            sma_pkg::SMA_SH_DLEFT: begin
                // Top and next form one 32-bit value shifted left.
                o_ext_high = i_w[16];
                o_ext_low = i_w[15];
                o_top = {i_w[14:0], i_next[15]};
                o_next = {i_next[14:0], i_yes};
            end
            sma_pkg::SMA_SH_CDRIGHT: begin
                o_ext_low = i_w[17];
                o_top = i_w[16:1];
                o_next = {i_w[0], i_next[15:1]};
            end
            sma_pkg::SMA_SH_DRIGHT: begin
                o_ext_low = i_w[17];
                o_top = {i_yes, i_w[15:1]};
                o_next = {i_w[0], i_next[15:1]};
            end
            default: begin
                o_top = i_w[15:0];
            end
        endcase
    end

endmodule : sma_shifter

`default_nettype wire

// >>> logic/sma_datapath.sv
`include "sma_params.svh"
`default_nettype none

// Summary of operation
// - Top widened to 17 bits, extensions clocked.
// - Low moves on ALU/shift; high on arithmetic.
// - Decode ALU field into eight conditional operations.
// - Condition false keeps top, shift still applies.
// - 18-bit intermediate result feeds the shifter.
// - Opcode bit 8 picks divisor or pseudo.
// - Pseudo reads divisor shifted left, ORed root.
// - Divisor top bit enters 17th-bit adder in pseudo or signed mode.
// - Pseudo write stores value times 256.
// - Selected and condition true: divisor ORs root.
// - Select bit set shifts root right once.
// - Shifter after ALU, single cycle.
// - Divisor and root update beside ALU.
// - Ten opcode bits form the micro-op fields.
// - Condition flag from bits 7:6 selection.
// - Subtraction carry is an inverted borrow.
// - Bits 1-3 select unconditional shift.
module sma_datapath (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_step_valid,
    input wire logic [15:0] i_opcode,
    input wire logic i_load,
    input wire logic [15:0] i_load_top,
    input wire logic [15:0] i_load_next,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [4:0] i_bus_addr,
    input wire logic [15:0] i_bus_wdata,
    output logic [15:0] o_top,
    output logic [15:0] o_next,
    output logic o_ext_low,
    output logic o_ext_high,
    output logic [15:0] o_divisor,
    output logic [15:0] o_root,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid
);

    sma_pkg::sma_state_s state_reg; // Everything the block stores.
    sma_pkg::sma_state_s state_next; // Its value for the next edge.

    // Micro-opcode fields; the return bit 5 is not ours and is ignored.
    logic [2:0] alu_field;
    logic [1:0] cond_field;
    logic [2:0] shift_field;
    logic sel_pseudo;
    logic signed_mode;
    logic is_arith;
    logic [15:0] pseudo_val;
    logic [15:0] operand;
    logic operand_bit16;
    logic [17:0] sum;
    logic carry16;
    logic cond_base;
    logic condition_flag;
    logic [17:0] w;
    logic sh_ext_high;
    logic sh_ext_low;
    logic [15:0] sh_top;
    logic [15:0] sh_next;
    logic wr_pseudo;
    logic wr_divisor;
    logic wr_root;

    assign alu_field = i_opcode[`SMA_ALU_LSB +: 3];
    assign cond_field = i_opcode[`SMA_COND_LSB +: 2];
    assign shift_field = i_opcode[`SMA_SHIFT_LSB +: 3];
    assign sel_pseudo = i_opcode[`SMA_SEL_BIT];
    assign signed_mode = i_opcode[`SMA_SIGN_BIT];
    assign is_arith = (alu_field == sma_pkg::SMA_ALU_ADD) ||
                      (alu_field == sma_pkg::SMA_ALU_TSUB) ||
                      (alu_field == sma_pkg::SMA_ALU_RSUB);

    // The pseudo register has no storage; it is formed on every read.
    assign pseudo_val = {o_divisor[14:0], 1'b0} | o_root;
    assign operand = sel_pseudo ? pseudo_val : o_divisor;
    // The divisor top bit is the operand's 17th bit: shifted out by the pseudo
    // view, or sign extension in signed mode; unsigned mode sees a zero.
    assign operand_bit16 = (sel_pseudo | signed_mode) & o_divisor[15];

    // The 17-bit adder runs every cycle so the carry can feed the condition
    // without depending on the condition itself, which would form a loop.
    always_comb begin
        sum = {1'b0, o_ext_low, o_top} + {1'b0, operand_bit16, operand};
        if (alu_field == sma_pkg::SMA_ALU_TSUB) begin
            // Adding the complement plus one leaves carry set when non-negative.
            sum = {1'b0, o_ext_low, o_top} + {1'b0, ~operand_bit16, ~operand} +
                  18'h00001;
        end else if (alu_field == sma_pkg::SMA_ALU_RSUB) begin
            sum = {1'b0, operand_bit16, operand} + {1'b0, ~o_ext_low, ~o_top} +
                  18'h00001;
        end
    end
    assign carry16 = sum[17];

    // Condition flag selection.
    assign cond_base = is_arith ? carry16 : i_opcode[`SMA_SIGN_BIT];
    always_comb begin
        case (cond_field)
            2'b00: condition_flag = cond_base;
            2'b01: condition_flag = cond_base | o_ext_high;
            2'b10: condition_flag = i_opcode[`SMA_IR3_BIT] ? o_next[0] : o_top[0];
            2'b11: condition_flag = o_top[0] ^ o_next[0];
            default: condition_flag = 1'b0;
        endcase
    end

    // Conditional ALU stage producing the 18-bit intermediate result.
    always_comb begin
        w = {o_ext_high, o_ext_low, o_top};
        if (condition_flag) begin
            case (sma_pkg::sma_alu_e'(alu_field))
                sma_pkg::SMA_ALU_NOP: w = {o_ext_high, o_ext_low, o_top};
                sma_pkg::SMA_ALU_AND: w = {o_ext_high, o_ext_low, o_top & operand};
                sma_pkg::SMA_ALU_OR: w = {o_ext_high, o_ext_low, o_top | operand};
                sma_pkg::SMA_ALU_XOR: w = {o_ext_high, o_ext_low, o_top ^ operand};
                sma_pkg::SMA_ALU_LOAD: w = {o_ext_high, o_ext_low, operand};
                default: w = sum;
            endcase
        end
    end

    // Shifter after the ALU in the same cycle.
    sma_shifter u_shifter (
        .i_w(w),
        .i_next(o_next),
        .i_yes(condition_flag),
        .i_shift(shift_field),
        .o_ext_high(sh_ext_high),
        .o_ext_low(sh_ext_low),
        .o_top(sh_top),
        .o_next(sh_next)
    );

    assign wr_pseudo = i_bus_wr && (i_bus_addr == `SMA_ADDR_PSEUDO);
    assign wr_divisor = i_bus_wr && (i_bus_addr == `SMA_ADDR_DIVISOR);
    assign wr_root = i_bus_wr && (i_bus_addr == `SMA_ADDR_ROOT);

    // Next-state logic. A bus write wins over a step update of the same register,
    // since software restoring saved state must not be disturbed.
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = i_bus_rd;
        if (i_step_valid) begin
            state_next.top = sh_top;
            state_next.next = sh_next;
            state_next.ext_low = sh_ext_low;
            if (is_arith) begin
                state_next.ext_high = sh_ext_high;
            end
            if (sel_pseudo) begin
                // Dedicated OR and shift paths run beside the ALU.
                state_next.root = {1'b0, o_root[15:1]};
                if (condition_flag) begin
                    state_next.divisor = o_divisor | o_root;
                end
            end
        end else if (i_load) begin
            // Ordinary datapath load of the two stack-top registers.
            state_next.top = i_load_top;
            state_next.next = i_load_next;
        end
        if (wr_pseudo) begin
            state_next.divisor = i_bus_wdata << `SMA_PSEUDO_SHIFT;
        end else if (wr_divisor) begin
            state_next.divisor = i_bus_wdata;
        end
        if (wr_root) begin
            state_next.root = i_bus_wdata;
        end
        // Read data; unmapped addresses answer zero.
        if (i_bus_rd) begin
            case (i_bus_addr)
                `SMA_ADDR_PSEUDO: state_next.rd_data = pseudo_val;
                `SMA_ADDR_DIVISOR: state_next.rd_data = o_divisor;
                `SMA_ADDR_ROOT: state_next.rd_data = o_root;
                default: state_next.rd_data = `SMA_RST_WORD;
            endcase
        end
    end

    // State register; extension bits change only here, at the rising edge or on an asynchronous reset.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_top = state_reg.top;
    assign o_next = state_reg.next;
    assign o_ext_low = state_reg.ext_low;
    assign o_ext_high = state_reg.ext_high;
    assign o_divisor = state_reg.divisor;
    assign o_root = state_reg.root;
    assign o_rd_data = state_reg.rd_data;
    assign o_rd_valid = state_reg.rd_valid;

    a_high_ext_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_step_valid && is_arith) |=> $stable(o_ext_high))
        else $error("High extension bit moved outside an arithmetic step.");

    a_low_ext_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_step_valid && (alu_field != 3'h0 || shift_field != 3'h0)) |=> $stable(o_ext_low))
        else $error("Low extension bit moved without an ALU or shift.");

    a_root_shift_right: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_step_valid && sel_pseudo && !wr_root) |=> (o_root == ($past(o_root) >> 1)))
        else $error("Root register did not shift right.");

    a_root_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!(i_step_valid && sel_pseudo) && !wr_root) |=> $stable(o_root))
        else $error("Root register changed without select bit.");

    a_divisor_or_root: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_step_valid && sel_pseudo && condition_flag && !i_bus_wr) |=>
        (o_divisor == ($past(o_divisor) | $past(o_root))))
        else $error("Divisor was not ORed with root.");

    a_divisor_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!(i_step_valid && sel_pseudo && condition_flag) && !wr_pseudo && !wr_divisor) |=>
        $stable(o_divisor))
        else $error("Divisor changed without its condition.");

    a_pseudo_write_scale: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_pseudo |=> (o_divisor == {$past(i_bus_wdata[7:0]), 8'h00}))
        else $error("Pseudo write did not scale by 256.");

    a_pseudo_read_value: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_bus_rd && i_bus_addr == 5'h05) |=>
        (o_rd_valid && o_rd_data == (($past(o_divisor) << 1) | $past(o_root))))
        else $error("Pseudo read returned the wrong value.");

    a_false_keeps_top: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_step_valid && !condition_flag && shift_field == 3'h0) |=> $stable(o_top))
        else $error("Top changed with condition false and no shift.");

    a_load_operand: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_step_valid && condition_flag && alu_field == 3'h7 && shift_field == 3'h0) |=>
        (o_top == $past(operand)))
        else $error("Load operation did not copy the operand.");

endmodule : sma_datapath

`default_nettype wire

// >>> test/tb.sv
`default_nettype none

// Self-checking bench for the step-math datapath: stimulus changes on the falling edge,
// results are looked at one falling edge after the rising edge that takes them.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk, i_rst_n, i_step_valid, i_load, i_bus_wr, i_bus_rd;
    logic [15:0] i_opcode, i_load_top, i_load_next, i_bus_wdata;
    logic [4:0] i_bus_addr;
    logic [15:0] o_top, o_next, o_divisor, o_root, o_rd_data;
    logic o_ext_low, o_ext_high, o_rd_valid;
    int fails;
    int comparisons;
    logic [15:0] exp_top;

    sma_datapath sma_datapath_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_step_valid(i_step_valid),
        .i_opcode(i_opcode), .i_load(i_load), .i_load_top(i_load_top),
        .i_load_next(i_load_next), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
        .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .o_top(o_top),
        .o_next(o_next), .o_ext_low(o_ext_low), .o_ext_high(o_ext_high),
        .o_divisor(o_divisor), .o_root(o_root), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid)
    );

    // Free-running 200 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Compares one observed value with its expectation; one-bit flags are zero-extended.
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        comparisons++;
        if (seen !== expected) begin
            fails++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // Builds a step opcode; the return bit and the unused bit stay zero.
    function automatic logic [15:0] mk(input logic [2:0] alu, input logic sel,
                                       input logic [1:0] cond, input logic [2:0] sh,
                                       input logic s);
        return {4'h0, alu, sel, cond, 2'b00, sh, s};
    endfunction : mk

    // Low sixteen bits of each ALU code with the condition true; the extension bits
    // never reach these bits, so the table holds whatever state they are in.
    function automatic logic [15:0] alu_ref(input logic [2:0] a, input logic [15:0] t,
                                            input logic [15:0] d);
        case (a)
            3'b000: return t;
            3'b001: return t & d;
            3'b010: return t - d;
            3'b011: return t | d;
            3'b100: return t + d;
            3'b101: return t ^ d;
            3'b110: return d - t;
            default: return d;
        endcase
    endfunction : alu_ref

    // One-cycle peripheral write.
    task automatic bus_wr(input logic [4:0] addr, input logic [15:0] data);
        @(negedge i_clk);
        i_bus_wr = 1'b1;
        i_bus_addr = addr;
        i_bus_wdata = data;
        @(negedge i_clk);
        i_bus_wr = 1'b0;
    endtask : bus_wr

    // One-cycle read; the answer pulses in the following cycle.
    task automatic bus_rd(input logic [4:0] addr, input logic [15:0] expected);
        @(negedge i_clk);
        i_bus_rd = 1'b1;
        i_bus_addr = addr;
        @(negedge i_clk);
        i_bus_rd = 1'b0;
        check({15'h0000, o_rd_valid}, 16'h0001);
        check(o_rd_data, expected);
    endtask : bus_rd

    // Ordinary load of top and next.
    task automatic load(input logic [15:0] t, input logic [15:0] n);
        @(negedge i_clk);
        i_load = 1'b1;
        i_load_top = t;
        i_load_next = n;
        @(negedge i_clk);
        i_load = 1'b0;
    endtask : load

    // One step-math instruction.
    task automatic step(input logic [15:0] op);
        @(negedge i_clk);
        i_step_valid = 1'b1;
        i_opcode = op;
        @(negedge i_clk);
        i_step_valid = 1'b0;
    endtask : step

    // Cuts a hang short well inside the cycle budget.
    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    initial begin
        {i_step_valid, i_load, i_bus_wr, i_bus_rd} = 4'h0;
        {i_opcode, i_load_top, i_load_next, i_bus_wdata} = 64'h0;
        i_bus_addr = 5'h00;
        fails = 0;
        comparisons = 0;
        i_rst_n = 1'b0;
        repeat (4) @(posedge i_clk);
        // Looked at on the falling edge, away from the edge that launches the outputs.
        @(negedge i_clk);
        check({o_top | o_next | o_divisor | o_root}, 16'h0000);
        check({14'h0000, o_ext_high, o_ext_low}, 16'h0000);
        i_rst_n = 1'b1;
        // Pseudo write scales by 256; an unmapped write must not disturb it.
        bus_wr(5'h05, 16'h12ab);
        bus_wr(5'h1f, 16'h5555);
        check(o_divisor, 16'hab00);
        bus_wr(5'h07, 16'h00f0);
        bus_rd(5'h05, 16'h56f0);
        bus_rd(5'h10, 16'h0000);
        // Pseudo operand with the condition true, then false.
        load(16'h0001, 16'h0000);
        step(mk(3'b111, 1'b1, 2'b10, 3'b000, 1'b0));
        check(o_top, 16'h56f0);
        check(o_divisor, 16'habf0);
        check(o_root, 16'h0078);
        step(mk(3'b001, 1'b1, 2'b10, 3'b000, 1'b0));
        check(o_top, 16'h56f0);
        check(o_divisor, 16'habf0);
        check(o_root, 16'h003c);
        // Subtraction without and with a borrow; extensions start at zero here.
        bus_wr(5'h06, 16'h0f0f);
        load(16'h3c35, 16'h0000);
        step(mk(3'b010, 1'b0, 2'b10, 3'b000, 1'b0));
        check(o_root, 16'h003c);
        check(o_top, 16'h2d26);
        check({14'h0000, o_ext_high, o_ext_low}, 16'h0002);
        load(16'h0001, 16'h0000);
        step(mk(3'b010, 1'b0, 2'b10, 3'b000, 1'b0));
        check(o_top, 16'hf0f2);
        check({14'h0000, o_ext_high, o_ext_low}, 16'h0001);
        // Signed add takes the divisor's top bit into the 17th bit.
        bus_wr(5'h06, 16'h8000);
        load(16'h0001, 16'h0000);
        step(mk(3'b100, 1'b0, 2'b10, 3'b000, 1'b1));
        check({o_ext_high, o_ext_low, o_top[15:2]}, 16'ha000);
        step(mk(3'b101, 1'b0, 2'b10, 3'b000, 1'b0));
        check({o_ext_high, o_ext_low, o_top[15:2]}, 16'h8000);
        step(mk(3'b100, 1'b0, 2'b10, 3'b000, 1'b0));
        check({o_ext_high, o_ext_low, o_top[15:2]}, 16'h2000);
        // Each condition-select code, logical operations only.
        bus_wr(5'h06, 16'h0f0f);
        load(16'h3c35, 16'h0000);
        step(mk(3'b001, 1'b0, 2'b00, 3'b000, 1'b0));
        check(o_top, 16'h3c35);
        step(mk(3'b001, 1'b0, 2'b00, 3'b000, 1'b1));
        check(o_top, 16'h0c05);
        step(mk(3'b011, 1'b0, 2'b01, 3'b000, 1'b0));
        check(o_top, 16'h0c05);
        load(16'h0001, 16'h0001);
        step(mk(3'b011, 1'b0, 2'b11, 3'b000, 1'b0));
        check(o_top, 16'h0001);
        load(16'h3c34, 16'h0003);
        step(mk(3'b001, 1'b0, 2'b10, 3'b100, 1'b0));
        check(o_top, 16'h0c04);
        check(o_next, 16'h0001);
        // Condition false: top kept, yet the left shift still acts on it.
        load(16'h3c34, 16'h0000);
        step(mk(3'b001, 1'b0, 2'b10, 3'b001, 1'b0));
        check(o_top, 16'h7868);
        check({15'h0000, o_ext_low}, 16'h0000);
        // Every ALU code against the divisor with the condition true.
        for (int a = 0; a < 8; a++) begin
            load(16'h3c35, 16'h0000);
            step(mk(a[2:0], 1'b0, 2'b10, 3'b000, 1'b0));
            exp_top = alu_ref(a[2:0], 16'h3c35, 16'h0f0f);
            check(o_top, exp_top);
        end
        // A subtraction leaves the high extension bit set, so code 01 turns the flag on
        // for a logical operation even with the manual bit clear.
        load(16'h3c35, 16'h0000);
        step(mk(3'b010, 1'b0, 2'b10, 3'b000, 1'b0));
        check({14'h0000, o_ext_high, o_ext_low}, 16'h0003);
        step(mk(3'b101, 1'b0, 2'b01, 3'b000, 1'b0));
        check(o_top, 16'h2229);
        // Remaining shift codes; for codes 011, 010 and 111 the flag is chosen to differ from the bit it could be
        // confused with, so a wrong carry-in source shows up in top.
        load(16'h8002, 16'h8001);
        step(mk(3'b000, 1'b0, 2'b10, 3'b011, 1'b0));
        check(o_top, 16'h4001);
        step(mk(3'b000, 1'b0, 2'b11, 3'b010, 1'b0));
        check(o_top, 16'ha000);
        step(mk(3'b000, 1'b0, 2'b10, 3'b101, 1'b0));
        check(o_top, 16'h4001);
        check(o_next, 16'h0003);
        step(mk(3'b000, 1'b0, 2'b10, 3'b110, 1'b0));
        check(o_top, 16'ha000);
        check(o_next, 16'h8001);
        step(mk(3'b000, 1'b0, 2'b00, 3'b111, 1'b0));
        check(o_top, 16'h5000);
        check(o_next, 16'h4000);
        check({14'h0000, o_ext_high, o_ext_low}, 16'h0003);
        // Pseudo-operand add while divisor and root update beside the ALU from old values.
        bus_wr(5'h06, 16'h0100);
        bus_wr(5'h07, 16'h0010);
        load(16'h0501, 16'h0000);
        step(mk(3'b100, 1'b1, 2'b10, 3'b000, 1'b0));
        check(o_top, 16'h0711);
        check(o_divisor, 16'h0110);
        check(o_root, 16'h0008);
        // The return bit lies outside the micro-op fields and changes nothing.
        step(mk(3'b101, 1'b0, 2'b10, 3'b000, 1'b0) | 16'h0020);
        check(o_top, 16'h0601);
        end_of_test();
    end
endmodule : tb

`default_nettype wire
